// [design/cfd_pkg.sv]
package cfd_pkg;

    // Address widths: 26 physical lines, 24-bit linear addresses.
    localparam int          PA_W     = 26;
    localparam int          LA_W     = 24;

    // Restart and vector addresses (linear, byte granular).
    localparam logic [23:0] RESET_PC = 24'hff_fff0;
    localparam logic [23:0] SMM_BASE = 24'h03_8000;
    localparam logic [23:0] NMI_VEC  = 24'h00_0100;
    localparam logic [23:0] IRQ_VEC  = 24'h00_0200;
    localparam logic [23:0] FLT_VEC  = 24'h00_0300;
    localparam logic [23:0] INV_VEC  = 24'h00_0400;

    // Coprocessor port: legacy low address with bit 23 raised.
    localparam logic [25:0] COP_ADDR = 26'h080_00f8;

    // Extra execution clocks and interrupt latency.
    localparam logic [2:0]  EXTRA_IO = 3'h4;
    localparam logic [2:0]  EXTRA_CR = 3'h1;
    localparam logic [2:0]  IRQ_LAT  = 3'h2;

    // Opcode class in bits 7:4 of an opcode byte; bits 2:0 pick a register.
    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_ALU, OP_SHF, OP_LD, OP_ST, OP_JMP,
        OP_IN, OP_OUT, OP_CR0, OP_COP, OP_RSM
    } cfd_op_t;

    // Decoded-instruction queue entry.
    typedef struct packed {
        logic [7:0]  opc;
        logic [31:0] imm;
        logic [23:0] pc;
    } cfd_dec_t;

    // One bus cycle request.
    typedef struct packed {
        logic        req;
        logic        we;
        logic        io;
        logic [25:0] addr;
        logic [31:0] wdata;
    } cfd_bus_t;

endpackage : cfd_pkg

// [design/cfd_pipeline.sv]
`timescale 1ns/1ps
`default_nettype none

// Small synchronous FIFO; a flush empties it in one clock.
module cfd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,       // Core clock.
    input  wire logic             rst,       // Synchronous reset.
    input  wire logic             flush,     // Discard all entries.
    input  wire logic             in_valid,  // Write request.
    output logic                  in_ready,  // Room for a word.
    input  wire logic [WIDTH-1:0] in_data,   // Word to write.
    output logic                  out_valid, // Head word present.
    input  wire logic             out_ready, // Head word taken.
    output logic [WIDTH-1:0]      out_data   // Head word.
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } cfd_fst_t;

    cfd_fst_t         q;
    cfd_fst_t         d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    if (DEPTH < 1) begin : g_bad
        $error("FIFO depth must be at least one.");
    end

    // Pointers wrap at DEPTH, so depths that are not powers of two work.
    always_comb begin
        in_ready  = q.cnt != CW'(DEPTH);
        out_valid = q.cnt != '0;
        out_data  = mem[q.rp];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        d         = q;
        if (push) begin
            d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
        end
        d.cnt = q.cnt + CW'(push) - CW'(pop);
    end

    // Storage has no reset; only the pointers and the count need a defined value.
    always_ff @(posedge clk) begin
        if (rst || flush) begin
            q <= '0;
        end else begin
            q <= d;
        end
        if (push) begin
            mem[q.wp] <= in_data;
        end
    end
endmodule : cfd_fifo

////////////////////////////////////////////////////////////////////////////////

module cfd_pipeline #(
    parameter int PF_DEPTH = 4, // Prefetch queue depth in words.
    parameter int DQ_DEPTH = 3, // Decoded queue depth.
    parameter int TLB_N    = 4  // Translation cache entries.
) (
    input  wire logic           clk,                 // Core clock, 40 MHz.
    input  wire logic           rst,                 // Synchronous reset, high.
    output var cfd_pkg::cfd_bus_t bus_o,             // Bus cycle request.
    input  wire logic           bus_ack,             // Bus cycle ends.
    input  wire logic [31:0]    bus_rdata,           // Read data with ack.
    input  wire logic           mgmt_interrupt_in_n, // Management interrupt, low.
    output logic                mgmt_active_out_n,   // Management state, low.
    input  wire logic           maskable_irq_in,     // Maskable interrupt.
    input  wire logic           nmi_in,              // Non-maskable interrupt.
    output logic                irq_ack,             // Interrupt vectored.
    input  wire logic [23:0]    seg_base,            // Cached segment base.
    input  wire logic [23:0]    seg_limit,           // Cached segment limit.
    output logic                tlb_miss,            // Mapping wanted.
    output logic [11:0]         miss_vpn,            // Page that missed.
    input  wire logic           tlb_fill,            // Mapping supplied.
    input  wire logic [13:0]    fill_pfn,            // Frame for miss_vpn.
    output logic                fault,               // Segment violation.
    output logic                invalid_op,          // Invalid opcode.
    output logic                retire,              // Instruction done.
    output logic                paging_on            // Paging enabled.
);
    localparam int VW = $clog2(TLB_N);

    typedef enum logic [1:0] {EX_RUN, EX_WAIT, EX_BUS, EX_IRQ} cfd_ex_t;
    typedef enum logic {DC_OPC, DC_IMM} cfd_dc_t;

    typedef struct packed {
        cfd_ex_t                  ex;
        cfd_dc_t                  dc;
        logic                     system_mgmt_state;
        logic                     act_n;
        logic                     paging;
        logic                     nmi;
        logic [23:0]              save_pc;
        logic [23:0]              fpc;
        logic                     busy;
        logic                     own;
        logic                     drop;
        logic                     miss;
        logic                     ack;
        logic                     flt;
        logic                     inv;
        logic                     ret;
        cfd_pkg::cfd_bus_t        bus;
        logic [1:0]               ptr;
        logic [7:0]               hopc;
        logic [23:0]              hpc;
        cfd_pkg::cfd_dec_t        cur;
        logic [2:0]               cnt;
        logic [23:0]              ea;
        logic [11:0]              mvpn;
        logic [TLB_N-1:0]         tv;
        logic [TLB_N-1:0][11:0]   tvpn;
        logic [TLB_N-1:0][13:0]   tpfn;
        logic [VW-1:0]            vic;
        logic [7:0][31:0]         regs;
    } cfd_st_t;

    cfd_st_t           q;
    cfd_st_t           d;
    logic              pf_in_ready;
    logic              pf_out_valid;
    logic [53:0]       pf_out;
    logic              pf_push;
    logic              pf_pop;
    logic              dq_in_valid;
    logic              dq_in_ready;
    cfd_pkg::cfd_dec_t dq_in;
    logic              dq_out_valid;
    cfd_pkg::cfd_dec_t dq_out;
    logic              dq_pop;
    logic              flush;
    logic [23:0]       tgt;
    logic              dreq;
    logic              dio;
    logic [23:0]       lin;
    logic              hit;
    logic [13:0]       hpfn;
    logic [25:0]       phys;
    logic [7:0]        byte_v;
    logic [2:0]        rr;
    logic [2:0]        rc;
    logic [63:0]       sh;
    logic              bad;

    if (PF_DEPTH < 1 || DQ_DEPTH < 1 || TLB_N < 2 || (TLB_N & (TLB_N - 1)) != 0)
    begin : g_bad
        $error("Queue depths must be positive and TLB_N a power of two.");
    end

    // Prefetch queue holds fetched words with their word address.
    cfd_fifo #(.WIDTH(54), .DEPTH(PF_DEPTH)) u_pfq (
        .clk       (clk),
        .rst       (rst),
        .flush     (flush),
        .in_valid  (pf_push),
        .in_ready  (pf_in_ready),
        .in_data   ({q.fpc[23:2], bus_rdata}),
        .out_valid (pf_out_valid),
        .out_ready (pf_pop),
        .out_data  (pf_out)
    );

    // Decoded-instruction queue between decoder and execution.
    cfd_fifo #(.WIDTH($bits(cfd_pkg::cfd_dec_t)), .DEPTH(DQ_DEPTH)) u_dq (
        .clk       (clk),
        .rst       (rst),
        .flush     (flush),
        .in_valid  (dq_in_valid),
        .in_ready  (dq_in_ready),
        .in_data   (dq_in),
        .out_valid (dq_out_valid),
        .out_ready (dq_pop),
        .out_data  (dq_out)
    );

    ////////////////////////////////////////////////////////////////////////////

    // Execution, bus arbitration, translation and decode in one pass.
    always_comb begin
        d      = q;
        d.ack  = 1'b0;
        d.flt  = 1'b0;
        d.inv  = 1'b0;
        d.ret  = 1'b0;
        flush  = 1'b0;
        tgt    = q.fpc;
        pf_push = 1'b0;
        pf_pop = 1'b0;
        dq_pop = 1'b0;
        dq_in_valid = 1'b0;
        dq_in  = '0;
        rr     = dq_out.opc[2:0];
        rc     = q.cur.opc[2:0];
        sh     = {q.regs[rr], q.regs[rr]} >> dq_out.imm[4:0];
        bad    = dq_out.imm[23:0] > seg_limit;
        byte_v = pf_out[8 * q.ptr +: 8];

        // Instruction boundary: management interrupt first, then interrupts.
        unique case (q.ex)
            EX_RUN: begin
                if (!mgmt_interrupt_in_n && !q.system_mgmt_state && dq_out_valid) begin
                    d.system_mgmt_state     = 1'b1;
                    d.act_n   = 1'b0;
                    d.save_pc = dq_out.pc;
                    flush     = 1'b1;
                    tgt       = cfd_pkg::SMM_BASE;
                end else if (nmi_in || (maskable_irq_in && !q.system_mgmt_state)) begin
                    d.ex  = EX_IRQ;
                    d.cnt = cfd_pkg::IRQ_LAT;
                    d.nmi = nmi_in;
                end else if (dq_out_valid) begin
                    dq_pop = 1'b1;
                    d.cur  = dq_out;
                    d.ea   = seg_base + dq_out.imm[23:0];
                    unique case (dq_out.opc[7:4])
                        cfd_pkg::OP_NOP: d.ret = 1'b1;
                        cfd_pkg::OP_ALU: begin
                            d.regs[rr] = q.regs[rr] + dq_out.imm;
                            d.ret      = 1'b1;
                        end
                        cfd_pkg::OP_SHF: begin
                            d.regs[rr] = sh[31:0];
                            d.ret      = 1'b1;
                        end
                        cfd_pkg::OP_LD, cfd_pkg::OP_ST: begin
                            if (bad) begin
                                d.flt = 1'b1;
                                flush = 1'b1;
                                tgt   = cfd_pkg::FLT_VEC;
                            end else begin
                                d.ex = EX_BUS;
                            end
                        end
                        cfd_pkg::OP_JMP: begin
                            flush = 1'b1;
                            tgt   = dq_out.imm[23:0];
                            d.ret = 1'b1;
                        end
                        cfd_pkg::OP_IN, cfd_pkg::OP_OUT: begin
                            d.ex  = EX_WAIT;
                            d.cnt = cfd_pkg::EXTRA_IO;
                        end
                        cfd_pkg::OP_CR0: begin
                            d.ex  = EX_WAIT;
                            d.cnt = cfd_pkg::EXTRA_CR;
                        end
                        cfd_pkg::OP_COP: d.ex = EX_BUS;
                        cfd_pkg::OP_RSM: begin
                            if (q.system_mgmt_state) begin
                                d.system_mgmt_state   = 1'b0;
                                d.act_n = 1'b1;
                                flush   = 1'b1;
                                tgt     = q.save_pc;
                                d.ret   = 1'b1;
                            end else begin
                                d.inv = 1'b1;
                                flush = 1'b1;
                                tgt   = cfd_pkg::INV_VEC;
                            end
                        end
                        default: begin
                            d.inv = 1'b1;
                            flush = 1'b1;
                            tgt   = cfd_pkg::INV_VEC;
                        end
                    endcase
                end
            end
            EX_WAIT: begin
                d.cnt = q.cnt - 3'h1;
                if (q.cnt == 3'h1) begin
                    if (q.cur.opc[7:4] == cfd_pkg::OP_CR0) begin
                        d.paging = q.cur.imm[31];
                        d.ret    = 1'b1;
                        d.ex     = EX_RUN;
                    end else begin
                        d.ex = EX_BUS;
                    end
                end
            end
            EX_BUS: begin
                if (q.own && q.busy && bus_ack) begin
                    if (q.cur.opc[7:4] == cfd_pkg::OP_LD || q.cur.opc[7:4] == cfd_pkg::OP_IN) begin
                        d.regs[rc] = bus_rdata;
                    end
                    d.ret = 1'b1;
                    d.ex  = EX_RUN;
                end
            end
            EX_IRQ: begin
                d.cnt = q.cnt - 3'h1;
                if (q.cnt == 3'h1) begin
                    d.ack = 1'b1;
                    flush = 1'b1;
                    tgt   = q.nmi ? cfd_pkg::NMI_VEC : cfd_pkg::IRQ_VEC;
                    d.ex  = EX_RUN;
                end
            end
        endcase

        // Translation: a data operand when one waits, else the fetch address.
        dreq = (q.ex == EX_BUS) && !q.busy;
        dio  = q.cur.opc[7:4] == cfd_pkg::OP_IN || q.cur.opc[7:4] == cfd_pkg::OP_OUT
            || q.cur.opc[7:4] == cfd_pkg::OP_COP;
        lin  = dreq ? q.ea : q.fpc;
        hit  = 1'b0;
        hpfn = '0;
        for (int i = 0; i < TLB_N; i++) begin
            if (q.tv[i] && q.tvpn[i] == lin[23:12]) begin
                hit  = 1'b1;
                hpfn = q.tpfn[i];
            end
        end
        phys = q.paging ? {hpfn, lin[11:0]} : {2'b00, lin};

        // Bus unit: one cycle in flight; data is served before prefetch.
        if (q.busy) begin
            if (bus_ack) begin
                d.busy    = 1'b0;
                d.bus.req = 1'b0;
                d.drop    = 1'b0;
                if (!q.own && !q.drop && !flush) begin
                    pf_push = 1'b1;
                    d.fpc   = q.fpc + 24'h00_0004;
                end
            end
        end else if (!q.miss) begin
            if (dreq) begin
                if (!dio && q.paging && !hit) begin
                    d.miss = 1'b1;
                    d.mvpn = lin[23:12];
                end else begin
                    d.bus.req   = 1'b1;
                    d.bus.io    = dio;
                    d.bus.we    = q.cur.opc[7:4] == cfd_pkg::OP_ST
                        || q.cur.opc[7:4] == cfd_pkg::OP_OUT || q.cur.opc[7:4] == cfd_pkg::OP_COP;
                    d.bus.wdata = q.regs[rc];
                    d.bus.addr  = (q.cur.opc[7:4] == cfd_pkg::OP_COP) ? cfd_pkg::COP_ADDR
                        : dio ? {10'h000, q.cur.imm[15:0]} : phys;
                    d.busy      = 1'b1;
                    d.own       = 1'b1;
                end
            end else if (pf_in_ready && !flush) begin
                if (q.paging && !hit) begin
                    d.miss = 1'b1;
                    d.mvpn = lin[23:12];
                end else begin
                    d.bus  = '{req: 1'b1, we: 1'b0, io: 1'b0, addr: phys, wdata: 32'h0000_0000};
                    d.busy = 1'b1;
                    d.own  = 1'b0;
                end
            end
        end

        // A supplied mapping replaces the oldest cache entry.
        if (q.miss && tlb_fill) begin
            d.tv[q.vic]   = 1'b1;
            d.tvpn[q.vic] = q.mvpn;
            d.tpfn[q.vic] = fill_pfn;
            d.vic         = q.vic + 1'b1;
            d.miss        = 1'b0;
        end

        // Decoder: opcodes byte by byte, an immediate as the whole next word.
        if (!flush && pf_out_valid && dq_in_ready) begin
            if (q.dc == DC_OPC) begin
                if (byte_v[7:4] >= cfd_pkg::OP_ALU && byte_v[7:4] <= cfd_pkg::OP_COP) begin
                    d.hopc = byte_v;
                    d.hpc  = {pf_out[53:32], q.ptr};
                    d.dc   = DC_IMM;
                    d.ptr  = 2'h0;
                    pf_pop = 1'b1;
                end else begin
                    dq_in_valid = 1'b1;
                    dq_in  = '{opc: byte_v, imm: 32'h0000_0000, pc: {pf_out[53:32], q.ptr}};
                    d.ptr  = q.ptr + 2'h1;
                    pf_pop = q.ptr == 2'h3;
                end
            end else begin
                dq_in_valid = 1'b1;
                dq_in  = '{opc: q.hopc, imm: pf_out[31:0], pc: q.hpc};
                d.dc   = DC_OPC;
                pf_pop = 1'b1;
            end
        end

        // Redirect: queues empty, fetch restarts, an in-flight fetch is dropped.
        if (flush) begin
            d.fpc  = {tgt[23:2], 2'b00};
            d.ptr  = tgt[1:0];
            d.dc   = DC_OPC;
            d.drop = q.busy && !q.own && !bus_ack;
        end
    end

    // All state in one register; reset starts fetching at the reset address.
    always_ff @(posedge clk) begin
        if (rst) begin
            q       <= '0;
            q.act_n <= 1'b1;
            q.fpc   <= cfd_pkg::RESET_PC;
        end else begin
            q <= d;
        end
    end

    assign bus_o             = q.bus;
    assign mgmt_active_out_n = q.act_n;
    assign irq_ack           = q.ack;
    assign tlb_miss          = q.miss;
    assign miss_vpn          = q.mvpn;
    assign fault             = q.flt;
    assign invalid_op        = q.inv;
    assign retire            = q.ret;
    assign paging_on         = q.paging;

    ////////////////////////////////////////////////////////////////////////////

    // Checks run on the core clock and sleep through reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_wait4;
        (q.ex == EX_WAIT) [*4] ##1 (q.ex == EX_BUS);
    endsequence

    sequence s_irq;
        (q.ex == EX_IRQ) [*2] ##1 irq_ack;
    endsequence

    smm_entry_a: assert property (
        q.ex == EX_RUN && !mgmt_interrupt_in_n && !q.system_mgmt_state && dq_out_valid
        |=> q.system_mgmt_state && !mgmt_active_out_n && !dq_out_valid)
        else $error("Management interrupt not taken.");
    act_pin_a: assert property (mgmt_active_out_n == !q.system_mgmt_state)
        else $error("Active pin disagrees with state.");
    rsm_inv_a: assert property (
        dq_pop && dq_out.opc[7:4] == cfd_pkg::OP_RSM && !q.system_mgmt_state |=> invalid_op)
        else $error("Resume outside management state accepted.");
    io_extra_a: assert property (
        dq_pop && dq_out.opc[7:4] == cfd_pkg::OP_IN |=> s_wait4)
        else $error("Port input extra clocks wrong.");
    irq_lat_a: assert property (
        (q.ex != EX_IRQ) ##1 (q.ex == EX_IRQ) |-> s_irq)
        else $error("Interrupt latency wrong.");
    data_prio_a: assert property (dreq && !q.miss |=> !(q.busy && !q.own))
        else $error("Prefetch beat a data cycle.");
    imm_once_a: assert property (
        q.dc == DC_IMM && pf_out_valid && dq_in_ready && !flush
        |-> dq_in_valid && pf_pop ##1 q.dc == DC_OPC)
        else $error("Immediate not taken in one clock.");
    phys_a: assert property (
        $rose(q.bus.req) && !q.bus.io && !q.paging |-> q.bus.addr[25:24] == 2'b00)
        else $error("Untranslated address out of range.");
    cop_a23_a: assert property (
        $rose(q.bus.req) && q.own && q.cur.opc[7:4] == cfd_pkg::OP_COP
        |-> q.bus.addr[23] && q.bus.io)
        else $error("Coprocessor cycle without bit 23.");
    flush_a: assert property (flush |=> !pf_out_valid && !dq_out_valid)
        else $error("Queues not emptied on redirect.");

endmodule : cfd_pipeline

`default_nettype wire

// [testbench/cfd_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Memory and I/O on the far side; acks after a random wait of 0 to 3 cycles.
module cfd_mem_model (
    input  wire logic              clk,       // Core clock.
    input  wire cfd_pkg::cfd_bus_t bus_i,     // Cycle request.
    output logic                   bus_ack,   // Cycle end pulse.
    output logic [31:0]            bus_rdata, // Read data.
    input  wire logic              tlb_miss,  // Mapping wanted.
    output logic                   tlb_fill,  // Mapping pulse.
    output logic [13:0]            fill_pfn   // Frame supplied.
);
    int wait_n = 0;
    assign fill_pfn = 14'h0000;
    // Program image; anything unlisted reads as a no-op word.
    function automatic logic [31:0] word_at(input logic [25:0] a);
        case (a)
            26'h0ff_fff0: word_at = 32'h0000_0050;
            26'h0ff_fff4: word_at = 32'h0000_1000;
            26'h000_1000: word_at = 32'h0000_00a0;
            26'h000_0400: word_at = 32'h0000_0060;
            26'h000_0404: word_at = 32'h0000_0055;
            26'h000_0408: word_at = 32'h0000_0090;
            26'h000_0410: word_at = 32'h0000_0030;
            26'h000_0414: word_at = 32'h00ff_ffff;
            26'h003_8000: word_at = 32'h0000_00a0;
            default:      word_at = 32'h0000_0000;
        endcase
    endfunction : word_at
    // Data toggles between acks so a stale word is never mistaken for fresh.
    initial begin
        bus_ack = 1'b0;
        tlb_fill = 1'b0;
        bus_rdata = 32'h0000_0000;
    end
    always @(posedge clk) begin
        bus_ack <= 1'b0;
        tlb_fill <= tlb_miss && !tlb_fill;
        bus_rdata <= ~bus_rdata;
        if (bus_i.req && !bus_ack) begin
            if (wait_n == 0) begin
                bus_ack <= 1'b1;
                bus_rdata <= word_at(bus_i.addr);
                wait_n <= $urandom_range(3);
            end else begin
                wait_n <= wait_n - 1;
            end
        end
    end
endmodule : cfd_mem_model

`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk, rst, smi_n, irq, nmi, ack, fill, act_n, iack, miss, flt, inv, ret, pg, pr, pa;
    cfd_pkg::cfd_bus_t bus;
    logic [31:0] rdata;
    logic [13:0] pfn;
    logic [11:0] vpn;
    logic [31:0] expq[$];
    int failures = 0, checks_done = 0, cycles = 0;
    cfd_pipeline u_cfd_pipeline (.clk(clk), .rst(rst), .bus_o(bus), .bus_ack(ack),
        .bus_rdata(rdata), .mgmt_interrupt_in_n(smi_n), .mgmt_active_out_n(act_n),
        .maskable_irq_in(irq), .nmi_in(nmi), .irq_ack(iack), .seg_base(24'h00_0000),
        .seg_limit(24'h00_8000), .tlb_miss(miss), .miss_vpn(vpn), .tlb_fill(fill),
        .fill_pfn(pfn), .fault(flt), .invalid_op(inv), .retire(ret), .paging_on(pg));
    cfd_mem_model u_cfd_mem_model (.clk(clk), .bus_i(bus), .bus_ack(ack),
        .bus_rdata(rdata), .tlb_miss(miss), .tlb_fill(fill), .fill_pfn(pfn));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            failures++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic tally_and_finish;
        if (failures == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // Each event observed is matched against the oldest note.
    task automatic see(input logic [31:0] ev);
        check(ev, (expq.size() > 0) ? expq.pop_front() : 32'hffff_ffff);
    endtask : see
    // Outputs are sampled mid-cycle, where registered values have settled.
    always @(negedge clk) begin
        if (!rst) begin
            if (inv === 1'b1) see(32'h0100_0000);
            if (bus.req === 1'b1 && pr !== 1'b1 && bus.io === 1'b1) see({5'h1, bus.we, bus.addr});
            if (flt === 1'b1) see(32'h0c00_0000);
            if (act_n !== pa) see({31'h0400_0000, act_n});
            if (iack === 1'b1) see(32'h1400_0000);
        end
        pr <= bus.req;
        pa <= act_n;
    end
    // A hang is cut short well beyond the expected run length.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic wait_q(input int n);
        while (expq.size() > n) @(posedge clk);
    endtask : wait_q
    initial begin
        void'($urandom(32'h300d_d30d));
        rst = 1'b1;
        smi_n = 1'b1;
        irq = 1'b0;
        nmi = 1'b0;
        repeat (10) @(posedge clk);
        #2 rst = 1'b0;
        expq = '{32'h0100_0000, {5'h1, 1'b0, 26'h000_0055}, {6'h3, cfd_pkg::COP_ADDR},
                 32'h0c00_0000, 32'h0800_0000, 32'h0800_0001, 32'h1400_0000};
        check({31'h0, act_n}, 32'h0000_0001);
        wait_q(3);
        @(posedge clk);
        #2 smi_n = 1'b0;
        while (act_n !== 1'b0) @(posedge clk);
        #2 smi_n = 1'b1;
        wait_q(1);
        @(posedge clk);
        #2 nmi = 1'b1;
        // Drop the request in the acknowledge cycle, or the next boundary takes it again.
        while (iack !== 1'b1) begin
            @(posedge clk);
            #2;
        end
        nmi = 1'b0;
        wait_q(0);
        repeat (20) @(posedge clk);
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire
